/* File: hdl/tppwm_top.sv */
// Three-phase PWM timebase, up/down counting, with AXI4-Lite registers
// What this block does
// - After reset the timebase counter counts upward.
// - While running, the counter steps on each selected count tick except the valley hold tick.
// - Counter equal to cycle register requests peak interrupt, flagged at next strobe.
// - From the peak match tick itself the counter decrements.
// - Direction status goes from 1 to 0 at the peak match.
// - Peak reload enable copies all duty buffers into duty registers at peak.
// - Reaching zero while down requests underflow interrupt, flagged at next strobe.
// - At zero underflow the cycle buffer is copied into the cycle register.
// - Valley reload enable copies all duty buffers into duty registers at zero.
// - At the valley zero lasts two count ticks before counting up.
// - Direction status returns from 0 to 1 after the first zero tick, one tick before counting up.
// - Up/down cycling repeats until the run bit is cleared.
// - A PWM phase output is high while counter is at or above its duty.
// - Comparator results reach the phase pins exactly two clocks later.
// - Count clock selection is bits 0 and 1 of the second control register.
// - Writing run bit 1 starts counting, writing 0 halts it.
`timescale 1ns/1ps
module tppwm_top
    import tppwm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock, reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU instruction timing
    input wire logic instruction_start_strobe,
    // Phase pins and interrupt
    output logic [NPH-1:0] phase_pin,
    output logic irq
);
    // Bus capture
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Registers
    logic [15:0] ctrl0;
    logic [15:0] second_control_register;
    logic [CNT_W-1:0] cycle_buffer;
    logic [CNT_W-1:0] cycle_register;
    logic [CNT_W-1:0] timebase_counter;
    logic [CNT_W-1:0] phase_duty_buffer [NPH];
    logic [CNT_W-1:0] phase_duty_register [NPH];
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [1:0] irq_pend;
    tppwm_state_t state;
    logic count_direction_status;

    // Next values
    tppwm_state_t next_state;
    logic [CNT_W-1:0] next_counter;
    logic next_dir;
    logic peak_ev;
    logic uflow_ev;
    logic [1:0] next_pend;
    logic [1:0] next_stat;
    logic [31:0] next_rdata;
    logic next_rok;

    // Decode
    wire counter_run_bit = second_control_register[CTRL1_RUN];
    wire count_clock_select_lsb = second_control_register[CTRL1_CKSEL_LSB];
    wire count_clock_select_msb = second_control_register[CTRL1_CKSEL_MSB];
    wire peak_reload_enable = ctrl0[CTRL0_PEAK_RLD];
    wire valley_reload_enable = ctrl0[CTRL0_VALLEY_RLD];
    wire [NPH-1:0] phase_pwm_en = ctrl0[CTRL0_PH_EN +: NPH];
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire wr_ctrl0 = wr_go && (aw_addr == OFF_CTRL0);
    wire wr_ctrl1 = wr_go && (aw_addr == OFF_CTRL1);
    wire wr_cbuf = wr_go && (aw_addr == OFF_CYC_BUF);
    wire wr_irq_clr = wr_go && (aw_addr == OFF_IRQ_CLR);
    wire wr_irq_en = wr_go && (aw_addr == OFF_IRQ_EN);
    wire wa_dbuf = (aw_addr >= OFF_DBUF_U) && (aw_addr <= OFF_DBUF_W);
    wire [7:0] wa_doff = aw_addr - OFF_DBUF_U;
    wire [1:0] wa_didx = wa_doff[3:2];
    wire wa_ok = (aw_addr[1:0] == 2'h0) && (aw_addr <= OFF_IRQ_EN);
    wire [7:0] ra_doff = s_axi_araddr - OFF_DBUF_U;
    wire [7:0] ra_roff = s_axi_araddr - OFF_DUTY_U;
    wire [1:0] ra_didx = ra_doff[3:2];
    wire [1:0] ra_ridx = ra_roff[3:2];
    wire tick;
    wire halted_load = !counter_run_bit;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    tppwm_prescale u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(counter_run_bit),
        .sel({count_clock_select_msb, count_clock_select_lsb}),
        .tick(tick)
    );

    // Counting sequence
    always_comb begin
        next_state = state;
        next_counter = timebase_counter;
        next_dir = count_direction_status;
        peak_ev = 1'b0;
        uflow_ev = 1'b0;
        if (counter_run_bit && tick) begin
            unique case (state)
                TPPWM_UP: begin
                    // At or above also catches a cycle lowered below count
                    if (timebase_counter >= cycle_register) begin
                        peak_ev = 1'b1;
                        next_state = TPPWM_DOWN;
                        next_dir = 1'b0;
                        if (timebase_counter != '0) begin
                            next_counter = timebase_counter - 1'b1;
                        end
                    end else begin
                        next_counter = timebase_counter + 1'b1;
                    end
                end
                TPPWM_DOWN: begin
                    if (timebase_counter <= 1) begin
                        uflow_ev = 1'b1;
                        next_counter = '0;
                        next_state = TPPWM_VALLEY;
                    end else begin
                        next_counter = timebase_counter - 1'b1;
                    end
                end
                TPPWM_VALLEY: begin
                    // Zero stays for a second tick, then the climb restarts
                    next_state = TPPWM_UP;
                    next_dir = 1'b1;
                end
                default: begin
                    next_state = TPPWM_UP;
                    next_dir = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= TPPWM_UP;
            count_direction_status <= 1'b1;
            timebase_counter <= '0;
        end else if (ce) begin
            state <= next_state;
            count_direction_status <= next_dir;
            timebase_counter <= next_counter;
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0 <= CTRL0_RST;
            second_control_register <= CTRL1_RST;
            irq_en <= 2'h0;
        end else if (ce) begin
            if (wr_ctrl0) begin
                ctrl0 <= merge16(ctrl0, w_data, w_strb);
            end
            if (wr_ctrl1) begin
                second_control_register <=
                    merge16(second_control_register, w_data, w_strb);
            end
            if (wr_irq_en && w_strb[0]) begin
                irq_en <= w_data[1:0];
            end
        end
    end

    // Cycle register; a halted counter lets buffer writes pass straight on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycle_buffer <= CYCLE_RST;
            cycle_register <= CYCLE_RST;
        end else if (ce) begin
            if (wr_cbuf) begin
                cycle_buffer <= merge16(cycle_buffer, w_data, w_strb);
            end
            if (wr_cbuf && halted_load) begin
                cycle_register <= merge16(cycle_buffer, w_data, w_strb);
            end else if (uflow_ev) begin
                cycle_register <= cycle_buffer;
            end
        end
    end

    // Duty buffers and duty registers, one pair per phase
    for (genvar i = 0; i < NPH; i++) begin : g_duty
        wire wr_me = wr_go && wa_dbuf && (wa_didx == 2'(i));
        wire [15:0] wval = merge16(phase_duty_buffer[i], w_data, w_strb);
        wire peak_ld = peak_ev && peak_reload_enable;
        wire valley_ld = uflow_ev && valley_reload_enable;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                phase_duty_buffer[i] <= DUTY_RST;
                phase_duty_register[i] <= DUTY_RST;
            end else if (ce) begin
                if (wr_me) begin
                    phase_duty_buffer[i] <= wval;
                end
                if (wr_me && halted_load) begin
                    phase_duty_register[i] <= wval;
                end else if (peak_ld || valley_ld) begin
                    phase_duty_register[i] <= phase_duty_buffer[i];
                end
            end
        end

        tppwm_phase #(
            .CNT_W(CNT_W)
        ) u_phase (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .counter(timebase_counter),
            .duty(phase_duty_register[i]),
            .enable(phase_pwm_en[i]),
            .pin(phase_pin[i])
        );
    end

    // Events wait for the instruction start strobe; a new event beats a clear
    wire [1:0] ev = {uflow_ev, peak_ev};
    wire [1:0] strobe2 = {2{instruction_start_strobe}};
    wire [1:0] clr = (wr_irq_clr && w_strb[0]) ? w_data[1:0] : 2'h0;

    always_comb begin
        next_pend = (irq_pend & ~strobe2) | ev;
        next_stat = (irq_stat & ~clr) | (irq_pend & strobe2);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pend <= 2'h0;
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_pend <= next_pend;
            irq_stat <= next_stat;
            irq <= |(irq_stat & irq_en);
        end
    end

    // Read selection
    always_comb begin
        next_rdata = 32'h0;
        next_rok = 1'b1;
        if (s_axi_araddr[1:0] != 2'h0) begin
            next_rok = 1'b0;
        end else if (s_axi_araddr >= OFF_DBUF_U &&
                     s_axi_araddr <= OFF_DBUF_W) begin
            next_rdata[15:0] = phase_duty_buffer[ra_didx];
        end else if (s_axi_araddr >= OFF_DUTY_U &&
                     s_axi_araddr <= OFF_DUTY_W) begin
            next_rdata[15:0] = phase_duty_register[ra_ridx];
        end else begin
            unique case (s_axi_araddr)
                OFF_CTRL0: next_rdata[15:0] = ctrl0;
                OFF_CTRL1: next_rdata[15:0] = second_control_register;
                OFF_STATUS: next_rdata[STAT_DIR] = count_direction_status;
                OFF_CYC_BUF: next_rdata[15:0] = cycle_buffer;
                OFF_CYC_REG: next_rdata[15:0] = cycle_register;
                OFF_COUNTER: next_rdata[15:0] = timebase_counter;
                OFF_IRQ_STAT: next_rdata[1:0] = irq_stat;
                OFF_IRQ_CLR: next_rdata = 32'h0;
                OFF_IRQ_EN: next_rdata[1:0] = irq_en;
                default: next_rok = 1'b0;
            endcase
        end
    end

    // Write channels: address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else if (ce) begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

/* File: hdl/tppwm_pkg.sv */
// Shared constants for the three-phase up/down PWM timebase
package tppwm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CYC_BUF = 8'h0C;
    localparam logic [7:0] OFF_CYC_REG = 8'h10;
    localparam logic [7:0] OFF_COUNTER = 8'h14;
    localparam logic [7:0] OFF_DBUF_U = 8'h18;
    localparam logic [7:0] OFF_DBUF_W = 8'h20;
    localparam logic [7:0] OFF_DUTY_U = 8'h24;
    localparam logic [7:0] OFF_DUTY_W = 8'h2C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h34;
    localparam logic [7:0] OFF_IRQ_EN = 8'h38;
    // Field positions
    localparam int CTRL0_PEAK_RLD = 0;
    localparam int CTRL0_VALLEY_RLD = 1;
    localparam int CTRL0_PH_EN = 2;
    localparam int CTRL1_CKSEL_LSB = 0;
    localparam int CTRL1_CKSEL_MSB = 1;
    localparam int CTRL1_RUN = 3;
    localparam int STAT_DIR = 0;
    localparam int IRQ_PEAK = 0;
    localparam int IRQ_UFLOW = 1;
    // Sizes and reset values
    localparam int NPH = 3;
    localparam logic [15:0] CTRL0_RST = 16'h0000;
    localparam logic [15:0] CTRL1_RST = 16'h0000;
    localparam logic [15:0] CYCLE_RST = 16'hFFFF;
    localparam logic [15:0] DUTY_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        TPPWM_UP = 2'b00,
        TPPWM_DOWN = 2'b01,
        TPPWM_VALLEY = 2'b10
    } tppwm_state_t;
endpackage

/* File: hdl/tppwm_prescale.sv */
// Count clock prescaler: one tick every 1, 2, 4 or 8 cycles
`timescale 1ns/1ps
module tppwm_prescale (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic [1:0] sel,
    // Tick
    output logic tick
);
    logic [2:0] div;
    logic [2:0] mask;

    assign mask = (sel == 2'h0) ? 3'h0 :
                  (sel == 2'h1) ? 3'h1 :
                  (sel == 2'h2) ? 3'h3 : 3'h7;
    assign tick = run && ((div & mask) == mask);

    // Restarting from zero keeps the first tick after a start aligned
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= 3'h0;
        end else if (ce) begin
            div <= run ? div + 3'h1 : 3'h0;
        end
    end
endmodule

/* File: hdl/tppwm_phase.sv */
// One phase: magnitude comparator followed by a two-cycle pin delay
`timescale 1ns/1ps
module tppwm_phase #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Compare inputs
    input wire logic [CNT_W-1:0] counter,
    input wire logic [CNT_W-1:0] duty,
    input wire logic enable,
    // Pin
    output logic pin
);
    logic stage;
    logic cmp;

    assign cmp = enable && (counter >= duty);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage <= 1'b0;
            pin <= 1'b0;
        end else if (ce) begin
            stage <= cmp;
            pin <= stage;
        end
    end
endmodule

/* File: sim/tppwm_props.sv */
// Port-level assertions for the three-phase PWM timebase
`timescale 1ns/1ps
module tppwm_props
    import tppwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [NPH-1:0] phase_pin,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_reset_quiet;
        disable iff (1'b0)
        !aresetn |=> phase_pin == '0 && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_bvalid_holds;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rvalid_holds;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endproperty
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_arready_back;
        s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid;
    endproperty
    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    // The flag register is only cleared or masked by a bus write
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_bvalid);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not idle after reset");
    a_bvalid_holds: assert property (p_bvalid_holds)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (p_rvalid_holds)
        else $error("read data dropped early");
    a_write_answer: assert property (p_write_answer)
        else $error("write response timing wrong");
    a_read_answer: assert property (p_read_answer)
        else $error("read answer timing wrong");
    a_arready_back: assert property (p_arready_back)
        else $error("read channel not reopened");
    a_slverr_zero: assert property (p_slverr_zero)
        else $error("error read returned data");
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_irq: cover property ($rose(irq));
    c_peak_pin: cover property ($rose(phase_pin[0]));
endmodule
bind tppwm_top tppwm_props u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .phase_pin(phase_pin), .irq(irq)
);

/* File: sim/tppwm_gate_model.sv */
// Gate driver stand-in: measures pulse figures on each phase pin
`timescale 1ns/1ps
module tppwm_gate_model
    import tppwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Phase pins
    input wire logic [NPH-1:0] phase_pin,
    // Last high width, low width, rise period, rise count
    output logic [NPH-1:0][15:0] hi_len,
    output logic [NPH-1:0][15:0] lo_len,
    output logic [NPH-1:0][15:0] period,
    output logic [NPH-1:0][15:0] rises
);
    logic [NPH-1:0][15:0] run;
    logic [NPH-1:0][15:0] age;
    logic [NPH-1:0] last;
    // Widths are in clock samples, so a level held n cycles reads n
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last <= '0;
            run <= '0;
            age <= '0;
            rises <= '0;
        end else begin
            for (int i = 0; i < NPH; i++) begin
                last[i] <= phase_pin[i];
                run[i] <= (phase_pin[i] != last[i]) ? 16'h1 : run[i] + 16'h1;
                age[i] <= (phase_pin[i] && !last[i]) ? 16'h1 : age[i] + 16'h1;
                if (phase_pin[i] && !last[i]) begin
                    lo_len[i] <= run[i];
                    period[i] <= age[i];
                    rises[i] <= rises[i] + 16'h1;
                end
                if (!phase_pin[i] && last[i])
                    hi_len[i] <= run[i];
            end
        end
    end
endmodule

/* File: sim/tppwm_top_test.sv */
// Self-checking bench for the three-phase PWM timebase
`timescale 1ns/1ps
module tppwm_top_test
    import tppwm_pkg::*;
;
    localparam int LIMIT = 20000;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, strobe = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d1;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [NPH-1:0] pin;
    logic [NPH-1:0][15:0] hi_len, lo_len, period, rises;
    logic [31:0] seed = 32'hBC39;
    logic force_s = 1'b0, rnd_s = 1'b0;
    logic [15:0] c, r0;
    int n_errors = 0, n_checks = 0, cycles = 0;

    tppwm_top dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .instruction_start_strobe(strobe), .phase_pin(pin), .irq(irq)
    );
    tppwm_gate_model gates (
        .aclk(aclk), .aresetn(aresetn), .phase_pin(pin), .hi_len(hi_len),
        .lo_len(lo_len), .period(period), .rises(rises)
    );

    always #2.5 aclk = ~aclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Cycles spent on n count ticks at prescale setting s
    function automatic logic [31:0] exp_len(input logic [31:0] n, input int s);
        return n << s;
    endfunction

    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge aclk) begin
        seed <= xs(seed);
        strobe <= force_s | (rnd_s & seed[0]);
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        check(v, e);
    endtask

    // Edge wait: the pin must first leave level v, then reach it
    task automatic wait_pin(input int i, input logic v);
        while (pin[i] !== !v) @(posedge aclk);
        while (pin[i] !== v) @(posedge aclk);
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc(OFF_STATUS, 32'h1);
        rc(OFF_CYC_REG, 32'(CYCLE_RST));
        rc(OFF_COUNTER, 32'h0);
        wstrb <= 4'h1;
        wr(OFF_CYC_BUF, 32'hABCD);
        wstrb <= 4'hF;
        rc(OFF_CYC_REG, 32'hFFCD);
        rc(8'h3C, 32'h0);
        check(32'(resp), 32'(RESP_SLVERR));
        wr(8'h3C, 32'h5);
        check(32'(resp), 32'(RESP_SLVERR));
        wr(OFF_CTRL0, 32'h1C);
        wr(OFF_DBUF_U, 32'h1);
        wr(OFF_DBUF_U, 32'h0);
        check(32'(pin[0]), 32'h0);
        @(posedge aclk);
        check(32'(pin[0]), 32'h0);
        @(posedge aclk);
        check(32'(pin[0]), 32'h1);
        check(32'(pin[2]), 32'h1);
        wr(OFF_DBUF_U + 8'h4, 32'h1);
        for (int s = 0; s < 4; s++) begin
            c = 16'h4 + 16'(seed[2:0]);
            wr(OFF_CTRL1, 32'h0);
            wr(OFF_CYC_BUF, 32'(c));
            wr(OFF_DBUF_U, 32'(c));
            wr(OFF_CTRL1, 32'h8 | 32'(s));
            r0 = rises[0];
            while (rises[0] !== r0 + 16'h3) @(posedge aclk);
            check(32'(hi_len[0]), exp_len(1, s));
            check(32'(lo_len[1]), exp_len(2, s));
            check(32'(period[0]), exp_len(32'(2 * c + 1), s));
            check(32'(pin[2]), 32'h1);
        end
        wr(OFF_CTRL1, 32'h3);
        rd(OFF_COUNTER, d1);
        repeat (40) @(posedge aclk);
        rc(OFF_COUNTER, d1);
        wr(OFF_CTRL0, 32'h1D);
        wr(OFF_CTRL1, 32'hB);
        wait_pin(0, 1'b0);
        wr(OFF_DBUF_U + 8'h4, 32'h2);
        wr(OFF_CYC_BUF, 32'(c + 16'h2));
        rc(OFF_DUTY_U + 8'h4, 32'h1);
        rc(OFF_CYC_REG, 32'(c));
        wait_pin(0, 1'b0);
        rc(OFF_STATUS, 32'h0);
        rc(OFF_DUTY_U + 8'h4, 32'h2);
        wait_pin(1, 1'b1);
        rc(OFF_STATUS, 32'h1);
        rc(OFF_CYC_REG, 32'(c + 16'h2));
        wr(OFF_CTRL0, 32'h1E);
        wr(OFF_DBUF_U + 8'h4, 32'h1);
        wait_pin(0, 1'b0);
        rc(OFF_DUTY_U + 8'h4, 32'h2);
        wait_pin(1, 1'b1);
        rc(OFF_DUTY_U + 8'h4, 32'h1);
        // Events have been pending all along, but no strobe has moved them
        wr(OFF_IRQ_EN, 32'h3);
        check(32'(irq), 32'h0);
        rc(OFF_IRQ_STAT, 32'h0);
        force_s <= 1'b1;
        @(posedge aclk);
        force_s <= 1'b0;
        repeat (4) @(posedge aclk);
        check(32'(irq), 32'h1);
        rc(OFF_IRQ_STAT, 32'h3);
        wr(OFF_IRQ_CLR, 32'h3);
        rc(OFF_IRQ_STAT, 32'h0);
        check(32'(irq), 32'h0);
        rnd_s <= 1'b1;
        wait_pin(1, 1'b1);
        wait_pin(0, 1'b1);
        repeat (20) @(posedge aclk);
        rnd_s <= 1'b0;
        rc(OFF_IRQ_STAT, 32'h3);
        wr(OFF_IRQ_EN, 32'h0);
        @(posedge aclk);
        check(32'(irq), 32'h0);
        complete_run();
    end
endmodule
